// ---- hdl/io_cell_pkg.sv ----
`default_nettype none

package io_cell_pkg;

   // ***************************************************
   // Cell width and reset values
   // ***************************************************
   localparam int CELL_WIDTH = 1;         // One pad per cell
   localparam logic DATA_RST = 1'h0;      // Pad data level under reset
   localparam logic OE_RST = 1'h0;        // Pad floats under reset

   // ***************************************************
   // Output path modes
   // ***************************************************
   typedef enum logic [1:0] {
      sdr_flop,
      sdr_latch,
      ddr_generic
   } mode_t;

   localparam mode_t MODE_RST = sdr_flop; // Mode after reset

endpackage : io_cell_pkg

`default_nettype wire

// ---- hdl/out_path_if.sv ----
`default_nettype none

// ***************************************************
// Data path between the cell and its double-rate stage
// ***************************************************
interface out_path_if #(
   parameter int WIDTH = io_cell_pkg::CELL_WIDTH
);
   logic [WIDTH-1:0] even_d;   // Even data toward the stage
   logic [WIDTH-1:0] odd_d;    // Odd data toward the stage
   logic [WIDTH-1:0] rise_q;   // Rising-edge capture of even data
   logic [WIDTH-1:0] fall_q;   // Falling-edge retime of odd data
   logic [WIDTH-1:0] mux_q;    // Clock-steered pad data

   // Cell side feeds data and takes back the stage results
   modport feed (
      output even_d,
      output odd_d,
      input rise_q,
      input fall_q,
      input mux_q
   );

   // Stage side
   modport stage (
      input even_d,
      input odd_d,
      output rise_q,
      output fall_q,
      output mux_q
   );
endinterface : out_path_if

`default_nettype wire

// ---- hdl/ddr_out_stage.sv ----
`default_nettype none

// ***************************************************
// Double-rate output stage
// ***************************************************
module ddr_out_stage #(
   parameter int WIDTH = io_cell_pkg::CELL_WIDTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   out_path_if.stage path
);

   logic [WIDTH-1:0] rise_capture_reg_r;
   logic [WIDTH-1:0] rise_capture_reg_nxt;
   logic [WIDTH-1:0] odd_capture_r;
   logic [WIDTH-1:0] odd_capture_nxt;
   logic [WIDTH-1:0] fall_retime_reg_r;
   logic [WIDTH-1:0] fall_retime_reg_nxt;

   // Next values of the rising-edge pair
   always_comb begin
      if (sys_rst) begin
         rise_capture_reg_nxt = {WIDTH{io_cell_pkg::DATA_RST}};
         odd_capture_nxt = {WIDTH{io_cell_pkg::DATA_RST}};
      end else begin
         rise_capture_reg_nxt = path.even_d;
         odd_capture_nxt = path.odd_d;
      end
   end

   // Both inputs taken on the rising edge
   always_ff @(posedge clk) begin
      rise_capture_reg_r <= rise_capture_reg_nxt;
      odd_capture_r <= odd_capture_nxt;
   end

   // Next value of the falling-edge retime
   always_comb begin
      if (sys_rst) begin
         fall_retime_reg_nxt = {WIDTH{io_cell_pkg::DATA_RST}};
      end else begin
         fall_retime_reg_nxt = odd_capture_r;
      end
   end

   // Odd data moved half a cycle later
   always_ff @(negedge clk) begin
      fall_retime_reg_r <= fall_retime_reg_nxt;
   end

   // Clock-steered mux: even while high, odd while low
   assign path.mux_q = clk ? rise_capture_reg_r : fall_retime_reg_r;
   assign path.rise_q = rise_capture_reg_r;
   assign path.fall_q = fall_retime_reg_r;

endmodule : ddr_out_stage

`default_nettype wire

// ---- hdl/io_cell_out.sv ----
// Summary of operation
// - Output data and enable from core reach the pad through flip-flops, except latch-mode data, which passes a level latch.
// - Single-rate mode sends even data through exactly one storage element to pad.
// - Single-rate element is selectable as edge flip-flop or level latch.
// - Double-rate mode captures even and odd inputs on the rising clock edge.
// - Following falling edge moves captured odd data into a separate retime register.
// - Clock-driven mux alternates rising capture and falling retime onto the pad.
// - Output enable input passes one flip-flop that drives the buffer enable.
`default_nettype none

module io_cell_out #(
   parameter int WIDTH = io_cell_pkg::CELL_WIDTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire io_cell_pkg::mode_t mode_sel,
   input wire logic [WIDTH-1:0] even_data_in,
   input wire logic [WIDTH-1:0] odd_data_in,
   input wire logic [WIDTH-1:0] output_enable_in,
   output logic [WIDTH-1:0] pad_out,
   output logic [WIDTH-1:0] pad_oe,
   output io_cell_pkg::mode_t mode_active
);

   // ***************************************************
   // Declarations
   // ***************************************************
   io_cell_pkg::mode_t mode_r;
   io_cell_pkg::mode_t mode_nxt;
   logic [WIDTH-1:0] sdr_flop_r;
   logic [WIDTH-1:0] sdr_flop_nxt;
   logic [WIDTH-1:0] sdr_latch_q;
   logic [WIDTH-1:0] oe_r;
   logic [WIDTH-1:0] oe_nxt;
   logic [WIDTH-1:0] pad_sel;

   out_path_if #(.WIDTH(WIDTH)) path ();

   // ***************************************************
   // Mode selection
   // ***************************************************

   // Mode taken from core once per cycle
   always_comb begin
      if (sys_rst) begin
         mode_nxt = io_cell_pkg::MODE_RST;
      end else begin
         mode_nxt = mode_sel;
      end
   end

   // Mode register
   always_ff @(posedge clk) begin
      mode_r <= mode_nxt;
   end

   assign mode_active = mode_r;

   // ***************************************************
   // Single-rate flip-flop element
   // ***************************************************

   // Even data sampled on the rising edge
   always_comb begin
      if (sys_rst) begin
         sdr_flop_nxt = {WIDTH{io_cell_pkg::DATA_RST}};
      end else begin
         sdr_flop_nxt = even_data_in;
      end
   end

   // Flip-flop element
   always_ff @(posedge clk) begin
      sdr_flop_r <= sdr_flop_nxt;
   end

   // ***************************************************
   // Single-rate latch element
   // ***************************************************

   // One latch per bit, open while the clock is high
   for (genvar i = 0; i < WIDTH; i++) begin : g_latch
      always_latch begin
         if (sys_rst) begin
            sdr_latch_q[i] = io_cell_pkg::DATA_RST;
         end else if (clk) begin
            sdr_latch_q[i] = even_data_in[i];
         end
      end
   end

   // ***************************************************
   // Double-rate stage
   // ***************************************************
   assign path.even_d = even_data_in;
   assign path.odd_d = odd_data_in;

   // Capture, retime and clock-steered mux
   ddr_out_stage #(
      .WIDTH(WIDTH)
   ) u_ddr (
      .clk(clk),
      .sys_rst(sys_rst),
      .path(path.stage)
   );

   // ***************************************************
   // Pad data selection
   // ***************************************************

   // Exactly one element drives the pad in each single-rate mode; double-rate alternates two registers
   always_comb begin
      case (mode_r)
         io_cell_pkg::sdr_flop: begin
            pad_sel = sdr_flop_r;
         end
         io_cell_pkg::sdr_latch: begin
            pad_sel = sdr_latch_q;
         end
         io_cell_pkg::ddr_generic: begin
            pad_sel = path.mux_q;
         end
         default: begin
            pad_sel = {WIDTH{io_cell_pkg::DATA_RST}};
         end
      endcase
   end

   assign pad_out = pad_sel;

   // ***************************************************
   // Tri-state control
   // ***************************************************

   // Enable sampled on the rising edge
   always_comb begin
      if (sys_rst) begin
         oe_nxt = {WIDTH{io_cell_pkg::OE_RST}};
      end else begin
         oe_nxt = output_enable_in;
      end
   end

   // Single enable flip-flop per pad
   always_ff @(posedge clk) begin
      oe_r <= oe_nxt;
   end

   assign pad_oe = oe_r;

endmodule : io_cell_out

`default_nettype wire

// ---- verif/io_cell_properties.sv ----
`default_nettype none
// ***
// Output cell checks
// ***
module io_cell_props #(parameter int WIDTH = 1) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire io_cell_pkg::mode_t mode_sel,
   input wire logic [WIDTH-1:0] even_data_in,
   input wire logic [WIDTH-1:0] odd_data_in,
   input wire logic [WIDTH-1:0] output_enable_in,
   input wire logic [WIDTH-1:0] pad_out,
   input wire logic [WIDTH-1:0] pad_oe,
   input wire io_cell_pkg::mode_t mode_active
);
   timeunit 1ns;
   timeprecision 1ps;
   // Low until the first edge has passed, so no reset check sees power-up values
   logic live_r = 1'b0;
   always @(posedge clk) live_r <= 1'b1;
   default clocking dc @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Edge after a clean edge, then the mode in force
   sequence run_s; !$past(sys_rst); endsequence
   sequence ddr_s; run_s ##0 mode_active == io_cell_pkg::ddr_generic; endsequence
   oe_reg_a: assert property (run_s |-> pad_oe == $past(output_enable_in))
      else $error("enable not registered");
   mode_reg_a: assert property (run_s |-> mode_active == $past(mode_sel))
      else $error("mode not registered");
   sdr_flop_a: assert property (run_s ##0 mode_active == io_cell_pkg::sdr_flop
      |-> pad_out == $past(even_data_in)) else $error("flop data wrong");
   ddr_fall_a: assert property (ddr_s |-> pad_out == $past(odd_data_in))
      else $error("odd phase wrong");
   latch_hold_a: assert property (run_s ##0 mode_active == io_cell_pkg::sdr_latch
      |-> pad_out == even_data_in) else $error("latch hold wrong");
   rst_clear_a: assert property (disable iff (1'b0) live_r && $past(sys_rst) && sys_rst
      |-> pad_out == '0 && pad_oe == '0) else $error("reset not clean");
   ddr_rise_a: assert property (@(negedge clk) disable iff (sys_rst)
      mode_active == io_cell_pkg::ddr_generic |-> pad_out == $past(even_data_in))
      else $error("even phase wrong");
   latch_pass_a: assert property (@(negedge clk) disable iff (sys_rst)
      mode_active == io_cell_pkg::sdr_latch |-> pad_out == even_data_in)
      else $error("latch not open");
endmodule : io_cell_props
bind io_cell_out io_cell_props #(.WIDTH(WIDTH)) io_cell_props_i (.clk(clk), .sys_rst(sys_rst),
   .mode_sel(mode_sel), .even_data_in(even_data_in), .odd_data_in(odd_data_in),
   .output_enable_in(output_enable_in), .pad_out(pad_out), .pad_oe(pad_oe),
   .mode_active(mode_active));
`default_nettype wire

// ---- verif/core_feed.sv ----
`default_nettype none
// ***
// Core fabric stand-in
// ***
module core_feed (
   input wire logic clk,
   input wire logic [31:0] rnd,
   output logic even_o,
   output logic odd_o,
   output logic oe_o,
   output io_cell_pkg::mode_t mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Fresh values 5 ns after each rising edge, mode changes freely
   always @(posedge clk) begin
      #5;
      even_o = rnd[0];
      odd_o = rnd[8];
      oe_o = rnd[16];
      mode_o = io_cell_pkg::mode_t'(rnd[25:24] % 2'h3);
   end
endmodule : core_feed
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
// ***
// Cell bench
// ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic [31:0] rnd = 32'h379cdc35;
   logic even_d, odd_d, oe_d, pad_out, pad_oe, m_e, m_o, m_oe, exp_d;
   io_cell_pkg::mode_t mode_d, mode_active, m_mode;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   always #25 clk = ~clk;
   core_feed core_feed_i (.clk(clk), .rnd(rnd), .even_o(even_d), .odd_o(odd_d), .oe_o(oe_d),
      .mode_o(mode_d));
   io_cell_out io_cell_out_i (.clk(clk), .sys_rst(sys_rst), .mode_sel(mode_d),
      .even_data_in(even_d), .odd_data_in(odd_d), .output_enable_in(oe_d),
      .pad_out(pad_out), .pad_oe(pad_oe), .mode_active(mode_active));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %b expected %b", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   // Reference model, with the run's cycle ceiling
   always @(posedge clk) begin
      cyc++;
      if (cyc > 1000) begin
         num_errors++;
         $display("[ERR] %0t timeout", $time);
         print_verdict();
      end else begin
         m_mode = sys_rst ? io_cell_pkg::sdr_flop : mode_d;
         m_e = sys_rst ? 1'h0 : even_d;
         m_o = sys_rst ? 1'h0 : odd_d;
         m_oe = sys_rst ? 1'h0 : oe_d;
      end
   end
   // Random traffic in all modes, a reset in mid-run
   initial begin
      repeat (3) @(posedge clk);
      #5 sys_rst = 1'h0;
      for (int i = 0; i < 800; i++) begin
         @(posedge clk);
         #1 rnd = xs(rnd);
         #4 sys_rst = (i >= 400 && i < 402);
         #5;
         // Latch follows live data but is held clear while reset stands
         exp_d = (m_mode == io_cell_pkg::sdr_latch) ? (even_d & ~sys_rst) : m_e;
         chk(2'(pad_oe), 2'(m_oe));
         chk(2'(mode_active), 2'(m_mode));
         chk(2'(pad_out), 2'(exp_d));
         @(negedge clk);
         #10;
         exp_d = (m_mode == io_cell_pkg::sdr_latch) ? (even_d & ~sys_rst) : m_e;
         if (m_mode == io_cell_pkg::ddr_generic) chk(2'(pad_out), 2'(sys_rst ? 1'h0 : m_o));
         else chk(2'(pad_out), 2'(exp_d));
      end
      print_verdict();
   end
endmodule : tb
`default_nettype wire
